// [verilog/switch_ctl_pkg.sv]
// Purpose: shared constants and types for the switch control register
// Assumes: 32-bit register word, byte addressed, 4 KB register space
// Notes: field positions and reset values live here only

package switch_ctl_pkg;

	// register map
	localparam logic [11:0] SWITCH_CONTROL_OFFSET = 12'h000;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// field positions inside switch_control
	localparam int RESET_HALT_HOLD_BIT = 2;
	localparam int WRITE_LOCK_RELEASE_BIT = 3;
	localparam int PWR_BUDGET_UNLOCK_BIT = 4;
	localparam int DEVNUM_CHECK_LO = 9;
	localparam int DEVNUM_CHECK_HI = 10;
	localparam int BCAST_DROP_BIT = 19;

	// byte lane that carries each field
	localparam int LANE_LOW_FIELDS = 0;
	localparam int LANE_DEVNUM_CHECK = 1;
	localparam int LANE_BCAST_DROP = 2;

	// reset values
	localparam logic RESET_HALT_HOLD_RST = 1'b0;
	localparam logic WRITE_LOCK_RELEASE_RST = 1'b0;
	localparam logic PWR_BUDGET_UNLOCK_RST = 1'b0;
	localparam logic [1:0] DEVNUM_CHECK_RST = 2'h0;
	localparam logic BCAST_DROP_RST = 1'b0;

	// check level encodings
	localparam logic [1:0] DEVNUM_CHECK_ALL = 2'h0;
	localparam logic [1:0] DEVNUM_CHECK_CFG = 2'h1;
	localparam logic [1:0] DEVNUM_CHECK_NONE = 2'h2;
	localparam logic [1:0] DEVNUM_CHECK_RSVD = 2'h3;

	localparam int DEV_NUM_W = 5;
	localparam logic [4:0] DEV_NUM_ZERO = 5'h00;

	// fundamental reset sequence
	typedef enum logic [1:0] {
		SEQ_SAMPLE = 2'b00,
		SEQ_LOAD = 2'b01,
		SEQ_HALT = 2'b10,
		SEQ_RUN = 2'b11
	} seq_state_t;

endpackage

// [verilog/forward_policy_if.sv]
// Purpose: carries forwarding policy from the register to the filter
// Assumes: single clock domain
// Notes: ctrl drives, filt only reads

`timescale 1ns/10ps

interface forward_policy_if;
	import switch_ctl_pkg::*;

	logic [1:0] devnum_check_level;
	logic bcast_drop;
	logic run;

	modport ctrl (output devnum_check_level, output bcast_drop, output run);
	modport filt (input devnum_check_level, input bcast_drop, input run);
endinterface

// [verilog/tlp_policy_filter.sv]
// Purpose: per-TLP forwarding verdict from the switch control policy
// Assumes: one descriptor per clock, qualified by valid
// Notes: verdicts are registered, one cycle after the descriptor

`timescale 1ns/10ps

module tlp_policy_filter (
	input wire logic clk,
	input wire logic arst_n,
	forward_policy_if.filt policy,
	input wire logic tlp_valid,
	input wire logic ds_egress,
	input wire logic us_ingress,
	input wire logic id_routed,
	input wire logic cfg_request,
	input wire logic link_bus_hit,
	input wire logic [4:0] dev_num,
	input wire logic vdm_bcast_type1,
	output logic tlp_forward,
	output logic tlp_block,
	output logic tlp_discard,
	output logic credit_return
);
	import switch_ctl_pkg::*;

	logic devnum_hit;
	logic block_now;
	logic discard_now;
	logic next_forward;
	logic next_block;
	logic next_discard;
	logic next_credit;

	// verdict for the current descriptor
	always_comb begin
		devnum_hit = tlp_valid && ds_egress && id_routed && link_bus_hit &&
			(dev_num != DEV_NUM_ZERO);
		unique case (policy.devnum_check_level)
			DEVNUM_CHECK_ALL: block_now = devnum_hit;
			DEVNUM_CHECK_CFG: block_now = devnum_hit && cfg_request;
			DEVNUM_CHECK_NONE: block_now = 1'b0;
			DEVNUM_CHECK_RSVD: block_now = 1'b0; // never stored
		endcase
		discard_now = tlp_valid && us_ingress && vdm_bcast_type1 &&
			policy.bcast_drop;
		// nothing moves while the switch sits in quasi-reset
		next_forward = tlp_valid && policy.run && !block_now && !discard_now;
		next_block = policy.run && block_now;
		next_discard = policy.run && discard_now;
		// a silent drop hands credits back and raises no error
		next_credit = policy.run && discard_now;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tlp_forward <= 1'b0;
			tlp_block <= 1'b0;
			tlp_discard <= 1'b0;
			credit_return <= 1'b0;
		end else begin
			tlp_forward <= next_forward;
			tlp_block <= next_block;
			tlp_discard <= next_discard;
			credit_return <= next_credit;
		end
	end
endmodule

// [verilog/switch_global_control_register.sv]
// Purpose: switch-wide control register and its reset sequencing
// Assumes: ARST_N_IN is the switch fundamental reset
// Notes: one-cycle register strobes, answer one cycle later

`timescale 1ns/10ps

// How it works
// - halt bit holds switch in quasi-reset
// - quasi-reset still accepts slave SMBus writes
// - halt bit writable only during reset sequence
// - halt bit loads from boot vector strap
// - lock release gates all unlocked-write fields
// - lock release resets zero, sequence sets it
// - budget unlock makes budget values writable
// - budget unlock writable only when released
// - level zero blocks nonzero device ID TLPs
// - level one blocks only config requests
// - level two blocks no TLP by device number
// - drop bit discards upstream vendor broadcasts
// - discard returns credits, sets no errors
// - boot vector sampled on the first edge after fundamental reset
module switch_global_control_register (
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	// boot configuration vector and loader
	input wire logic BCV_RESET_HALT_IN,
	input wire logic EEPROM_DONE_IN,
	// register access port
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic REG_SMBUS_IN,
	input wire logic [switch_ctl_pkg::ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [switch_ctl_pkg::BE_W-1:0] REG_BE_IN,
	input wire logic [switch_ctl_pkg::DATA_W-1:0] REG_WDATA_IN,
	output logic [switch_ctl_pkg::DATA_W-1:0] REG_RDATA_OUT,
	output logic REG_ACK_OUT,
	output logic REG_ERR_OUT,
	// control levels to the rest of the switch
	output logic QUASI_RESET_OUT,
	output logic WRITE_LOCK_RELEASE_OUT,
	output logic PWR_BUDGET_WRITABLE_OUT,
	output logic [1:0] DEVNUM_CHECK_LEVEL_OUT,
	output logic BCAST_DROP_OUT,
	// TLP descriptor
	input wire logic TLP_VALID_IN,
	input wire logic TLP_DS_EGRESS_IN,
	input wire logic TLP_US_INGRESS_IN,
	input wire logic TLP_ID_ROUTED_IN,
	input wire logic TLP_CFG_REQ_IN,
	input wire logic TLP_LINK_BUS_HIT_IN,
	input wire logic [switch_ctl_pkg::DEV_NUM_W-1:0] TLP_DEV_NUM_IN,
	input wire logic TLP_VDM_BCAST_T1_IN,
	// TLP verdict
	output logic TLP_FORWARD_OUT,
	output logic TLP_BLOCK_OUT,
	output logic TLP_DISCARD_OUT,
	output logic CREDIT_RETURN_OUT
);
	import switch_ctl_pkg::*;

	// byte-lane merge of one bit
	function automatic logic lane_bit(
		input logic old_val,
		input logic [DATA_W-1:0] wdata,
		input logic [BE_W-1:0] be,
		input int pos,
		input int lane
	);
		lane_bit = be[lane] ? wdata[pos] : old_val;
	endfunction

	// read-back image of switch_control, reserved bits zero
	function automatic logic [DATA_W-1:0] ctrl_word(
		input logic halt,
		input logic unlock,
		input logic pbvu,
		input logic [1:0] level,
		input logic drop
	);
		logic [DATA_W-1:0] w;
		w = '0;
		w[RESET_HALT_HOLD_BIT] = halt;
		w[WRITE_LOCK_RELEASE_BIT] = unlock;
		w[PWR_BUDGET_UNLOCK_BIT] = pbvu;
		w[DEVNUM_CHECK_HI:DEVNUM_CHECK_LO] = level;
		w[BCAST_DROP_BIT] = drop;
		ctrl_word = w;
	endfunction

	// halt gating, quasi-reset and filter release share this decode
	function automatic logic seq_running(input seq_state_t s);
		seq_running = (s == SEQ_RUN);
	endfunction

	// reset sequence
	seq_state_t state;
	seq_state_t next_state;

	// switch_control fields
	logic reset_halt_hold;
	logic write_lock_release;
	logic power_budget_value_unlock;
	logic [1:0] downstream_devnum_check_level;
	logic broadcast_vendor_msg_drop;

	// their next values
	logic next_reset_halt_hold;
	logic next_write_lock_release;
	logic next_power_budget_value_unlock;
	logic [1:0] next_downstream_devnum_check_level;
	logic next_broadcast_vendor_msg_drop;

	// decode of the current request
	logic addr_hit;
	logic src_ok;
	logic wr_take;
	logic halt_wr_open;
	logic locked_wr_open;
	logic [1:0] level_wr;
	logic level_wr_ok;
	logic req_any;

	// next register answer
	logic [DATA_W-1:0] next_rdata;
	logic next_ack;
	logic next_err;

	// carrier to the forwarding filter
	forward_policy_if policy_bus ();

	// address decode and write acceptance
	always_comb begin
		addr_hit = (REG_ADDR_IN == SWITCH_CONTROL_OFFSET);
		// while halted only slave SMBus writes are taken
		src_ok = (state != SEQ_HALT) || REG_SMBUS_IN;
		wr_take = REG_WR_IN && addr_hit && src_ok;
		// halt bit frozen once normal operation runs
		halt_wr_open = !seq_running(state);
		// unlocked-write fields see the lock before this write
		locked_wr_open = write_lock_release;
		level_wr = REG_WDATA_IN[DEVNUM_CHECK_HI:DEVNUM_CHECK_LO];
		// encoding three is reserved and never stored
		level_wr_ok = (level_wr != DEVNUM_CHECK_RSVD);
	end

	// field updates: software writes, then the sequence start
	always_comb begin
		next_reset_halt_hold = reset_halt_hold;
		next_write_lock_release = write_lock_release;
		next_power_budget_value_unlock = power_budget_value_unlock;
		next_downstream_devnum_check_level = downstream_devnum_check_level;
		next_broadcast_vendor_msg_drop = broadcast_vendor_msg_drop;

		// software writes first, so the sequence below may override
		if (wr_take) begin
			// halt bit only moves before normal operation
			if (halt_wr_open) begin
				next_reset_halt_hold = lane_bit(reset_halt_hold,
					REG_WDATA_IN, REG_BE_IN, RESET_HALT_HOLD_BIT,
					LANE_LOW_FIELDS);
			end
			// lock release itself is plain read-write
			next_write_lock_release = lane_bit(write_lock_release,
				REG_WDATA_IN, REG_BE_IN, WRITE_LOCK_RELEASE_BIT,
				LANE_LOW_FIELDS);
			// unlocked-write field sees the old lock value
			if (locked_wr_open) begin
				next_power_budget_value_unlock = lane_bit(
					power_budget_value_unlock, REG_WDATA_IN, REG_BE_IN,
					PWR_BUDGET_UNLOCK_BIT, LANE_LOW_FIELDS);
			end
			// encoding three is reserved, keep the old level
			if (REG_BE_IN[LANE_DEVNUM_CHECK] && level_wr_ok) begin
				next_downstream_devnum_check_level = level_wr;
			end
			// drop bit sits alone in lane two
			next_broadcast_vendor_msg_drop = lane_bit(
				broadcast_vendor_msg_drop, REG_WDATA_IN, REG_BE_IN,
				BCAST_DROP_BIT, LANE_BCAST_DROP);
		end

		// the first edge after reset release opens the sequence
		if (state == SEQ_SAMPLE) begin
			// strap caught on the first edge after release
			next_reset_halt_hold = BCV_RESET_HALT_IN;
			// open the lock so the loader can reach locked fields
			next_write_lock_release = 1'b1;
		end
	end

	// sequence: sample, wait for the loader, then halt or run
	always_comb begin
		next_state = state;
		unique case (state)
			SEQ_SAMPLE: begin
				next_state = SEQ_LOAD;
			end
			SEQ_LOAD: begin
				// the halt bit as the loader left it picks the way
				if (EEPROM_DONE_IN) begin
					next_state = next_reset_halt_hold ? SEQ_HALT : SEQ_RUN;
				end
			end
			SEQ_HALT: begin
				// clearing the halt bit releases the switch
				if (!next_reset_halt_hold) begin
					next_state = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				// only a fundamental reset leaves normal operation
				next_state = SEQ_RUN;
			end
		endcase
	end

	// register answer: one cycle after the strobe
	always_comb begin
		// write and read together still earn a single answer
		req_any = REG_WR_IN || REG_RD_IN;
		next_ack = req_any;
		next_err = req_any && !addr_hit;
		next_rdata = '0;
		// a read shows the value from before a same-cycle write
		if (REG_RD_IN && addr_hit) begin
			next_rdata = ctrl_word(reset_halt_hold, write_lock_release,
				power_budget_value_unlock, downstream_devnum_check_level,
				broadcast_vendor_msg_drop);
		end
	end

	// sequence state; only a fundamental reset restarts it
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state <= SEQ_SAMPLE;
		end else begin
			state <= next_state;
		end
	end

	// control fields clear only on fundamental reset
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			reset_halt_hold <= RESET_HALT_HOLD_RST;
			write_lock_release <= WRITE_LOCK_RELEASE_RST;
			power_budget_value_unlock <= PWR_BUDGET_UNLOCK_RST;
			downstream_devnum_check_level <= DEVNUM_CHECK_RST;
			broadcast_vendor_msg_drop <= BCAST_DROP_RST;
		end else begin
			reset_halt_hold <= next_reset_halt_hold;
			write_lock_release <= next_write_lock_release;
			power_budget_value_unlock <= next_power_budget_value_unlock;
			downstream_devnum_check_level <=
				next_downstream_devnum_check_level;
			broadcast_vendor_msg_drop <= next_broadcast_vendor_msg_drop;
		end
	end

	// answer registers
	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			REG_RDATA_OUT <= '0;
			REG_ACK_OUT <= 1'b0;
			REG_ERR_OUT <= 1'b0;
		end else begin
			REG_RDATA_OUT <= next_rdata;
			REG_ACK_OUT <= next_ack;
			REG_ERR_OUT <= next_err;
		end
	end

	// levels straight from the field flops, quasi-reset from the sequence state
	always_comb begin
		// everything but the SMBus sits in quasi-reset until run
		QUASI_RESET_OUT = !seq_running(state);
		WRITE_LOCK_RELEASE_OUT = write_lock_release;
		PWR_BUDGET_WRITABLE_OUT = power_budget_value_unlock;
		DEVNUM_CHECK_LEVEL_OUT = downstream_devnum_check_level;
		BCAST_DROP_OUT = broadcast_vendor_msg_drop;
	end

	// policy to the forwarding filter
	assign policy_bus.devnum_check_level = downstream_devnum_check_level;
	assign policy_bus.bcast_drop = broadcast_vendor_msg_drop;
	assign policy_bus.run = seq_running(state);

	tlp_policy_filter filter_u (
		.clk(REF_CLK_IN),
		.arst_n(ARST_N_IN),
		.policy(policy_bus.filt),
		.tlp_valid(TLP_VALID_IN),
		.ds_egress(TLP_DS_EGRESS_IN),
		.us_ingress(TLP_US_INGRESS_IN),
		.id_routed(TLP_ID_ROUTED_IN),
		.cfg_request(TLP_CFG_REQ_IN),
		.link_bus_hit(TLP_LINK_BUS_HIT_IN),
		.dev_num(TLP_DEV_NUM_IN),
		.vdm_bcast_type1(TLP_VDM_BCAST_T1_IN),
		.tlp_forward(TLP_FORWARD_OUT),
		.tlp_block(TLP_BLOCK_OUT),
		.tlp_discard(TLP_DISCARD_OUT),
		.credit_return(CREDIT_RETURN_OUT)
	);
endmodule

// [verif/switch_ctl_chk.sv]
// Purpose: port-level checks of the switch control register
// Assumes: single clock, async active-low reset
// Notes: attached by bind, sees top-level ports only

`timescale 1ns/10ps

module switch_ctl_chk (
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [11:0] REG_ADDR_IN,
	input wire logic [31:0] REG_RDATA_OUT,
	input wire logic REG_ACK_OUT,
	input wire logic REG_ERR_OUT,
	input wire logic QUASI_RESET_OUT,
	input wire logic WRITE_LOCK_RELEASE_OUT,
	input wire logic PWR_BUDGET_WRITABLE_OUT,
	input wire logic [1:0] DEVNUM_CHECK_LEVEL_OUT,
	input wire logic BCAST_DROP_OUT,
	input wire logic TLP_VALID_IN,
	input wire logic TLP_DS_EGRESS_IN,
	input wire logic TLP_US_INGRESS_IN,
	input wire logic TLP_ID_ROUTED_IN,
	input wire logic TLP_CFG_REQ_IN,
	input wire logic TLP_LINK_BUS_HIT_IN,
	input wire logic [4:0] TLP_DEV_NUM_IN,
	input wire logic TLP_VDM_BCAST_T1_IN,
	input wire logic TLP_FORWARD_OUT,
	input wire logic TLP_BLOCK_OUT,
	input wire logic TLP_DISCARD_OUT,
	input wire logic CREDIT_RETURN_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	// request and descriptor qualifiers
	wire req = REG_WR_IN | REG_RD_IN;
	wire go = TLP_VALID_IN & ~QUASI_RESET_OUT;
	wire idhit = TLP_DS_EGRESS_IN & TLP_ID_ROUTED_IN & TLP_LINK_BUS_HIT_IN
		& (TLP_DEV_NUM_IN != 5'h00);
	wire [1:0] lvl = DEVNUM_CHECK_LEVEL_OUT;

	ack_timing_a: assert property (req |=> REG_ACK_OUT)
		else $error("no ack");
	unmapped_err_a: assert property (req && REG_ADDR_IN != 12'h000 |=>
		REG_ERR_OUT && REG_RDATA_OUT == 32'h0) else $error("unmapped access");
	reserved_zero_a: assert property (REG_ACK_OUT |->
		(REG_RDATA_OUT & 32'hFFF7_F9E3) == 32'h0) else $error("reserved set");
	level_legal_a: assert property (lvl != 2'h3)
		else $error("level three");
	run_sticks_a: assert property (!QUASI_RESET_OUT |=> !QUASI_RESET_OUT)
		else $error("quasi reset reentered");
	quasi_silent_a: assert property ($past(QUASI_RESET_OUT) |->
		!(TLP_FORWARD_OUT | TLP_BLOCK_OUT | TLP_DISCARD_OUT))
		else $error("verdict in quasi reset");
	budget_locked_a: assert property (!WRITE_LOCK_RELEASE_OUT |=>
		$stable(PWR_BUDGET_WRITABLE_OUT)) else $error("budget unlock moved");
	all_block_a: assert property (go && idhit && lvl == 2'h0 |=>
		TLP_BLOCK_OUT && !TLP_FORWARD_OUT) else $error("level0 not blocked");
	cfg_block_a: assert property (go && idhit && lvl == 2'h1 |=>
		TLP_BLOCK_OUT == $past(TLP_CFG_REQ_IN)) else $error("level1 verdict");
	none_block_a: assert property (go && lvl == 2'h2 |=> !TLP_BLOCK_OUT)
		else $error("level2 blocked");
	vdm_drop_a: assert property (go && TLP_US_INGRESS_IN &&
		TLP_VDM_BCAST_T1_IN && BCAST_DROP_OUT |=> TLP_DISCARD_OUT &&
		CREDIT_RETURN_OUT && !TLP_FORWARD_OUT) else $error("no discard");
endmodule

bind switch_global_control_register switch_ctl_chk i_chk (
	.REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .REG_WR_IN(REG_WR_IN),
	.REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .REG_ACK_OUT(REG_ACK_OUT),
	.REG_ERR_OUT(REG_ERR_OUT), .QUASI_RESET_OUT(QUASI_RESET_OUT),
	.WRITE_LOCK_RELEASE_OUT(WRITE_LOCK_RELEASE_OUT),
	.PWR_BUDGET_WRITABLE_OUT(PWR_BUDGET_WRITABLE_OUT),
	.DEVNUM_CHECK_LEVEL_OUT(DEVNUM_CHECK_LEVEL_OUT),
	.BCAST_DROP_OUT(BCAST_DROP_OUT), .TLP_VALID_IN(TLP_VALID_IN),
	.TLP_DS_EGRESS_IN(TLP_DS_EGRESS_IN), .TLP_US_INGRESS_IN(TLP_US_INGRESS_IN),
	.TLP_ID_ROUTED_IN(TLP_ID_ROUTED_IN), .TLP_CFG_REQ_IN(TLP_CFG_REQ_IN),
	.TLP_LINK_BUS_HIT_IN(TLP_LINK_BUS_HIT_IN), .TLP_DEV_NUM_IN(TLP_DEV_NUM_IN),
	.TLP_VDM_BCAST_T1_IN(TLP_VDM_BCAST_T1_IN),
	.TLP_FORWARD_OUT(TLP_FORWARD_OUT), .TLP_BLOCK_OUT(TLP_BLOCK_OUT),
	.TLP_DISCARD_OUT(TLP_DISCARD_OUT), .CREDIT_RETURN_OUT(CREDIT_RETURN_OUT));

// [verif/testbench.sv]
// Purpose: directed bench for the switch control register
// Assumes: inputs change on the falling edge, answers one cycle later
// Notes: expected words built by hand from field positions

`timescale 1ns/10ps

module testbench;
	import switch_ctl_pkg::*;
	logic clk = 1'h0, rst_n = 1'h0, strap = 1'h0, done = 1'h0;
	logic wr = 1'h0, rd = 1'h0, smb = 1'h0, tv = 1'h0, ds = 1'h0, us = 1'h0;
	logic idr = 1'h0, cfg = 1'h0, hit = 1'h0, vdm = 1'h0;
	logic [11:0] addr = 12'h000;
	logic [3:0] be = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [4:0] dev = 5'h00;
	logic [31:0] rdat;
	logic [1:0] lvl;
	logic ack, err, quasi, lock, pbw, drop, fwd, blk, dis, cred;
	int fail_count = 0;
	int compares = 0;

	// 25 MHz reference
	always #20 clk = ~clk;

	switch_global_control_register i_dut (.REF_CLK_IN(clk), .ARST_N_IN(rst_n),
		.BCV_RESET_HALT_IN(strap), .EEPROM_DONE_IN(done), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_SMBUS_IN(smb), .REG_ADDR_IN(addr), .REG_BE_IN(be),
		.REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .REG_ACK_OUT(ack),
		.REG_ERR_OUT(err), .QUASI_RESET_OUT(quasi),
		.WRITE_LOCK_RELEASE_OUT(lock), .PWR_BUDGET_WRITABLE_OUT(pbw),
		.DEVNUM_CHECK_LEVEL_OUT(lvl), .BCAST_DROP_OUT(drop),
		.TLP_VALID_IN(tv), .TLP_DS_EGRESS_IN(ds), .TLP_US_INGRESS_IN(us),
		.TLP_ID_ROUTED_IN(idr), .TLP_CFG_REQ_IN(cfg),
		.TLP_LINK_BUS_HIT_IN(hit), .TLP_DEV_NUM_IN(dev),
		.TLP_VDM_BCAST_T1_IN(vdm), .TLP_FORWARD_OUT(fwd),
		.TLP_BLOCK_OUT(blk), .TLP_DISCARD_OUT(dis), .CREDIT_RETURN_OUT(cred));

	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask

	// one register access; ack is a one-cycle pulse, so look at once
	task acc(input logic w, input logic s, input logic [11:0] a,
		input logic [3:0] b, input logic [31:0] d, input logic ee);
		@(negedge clk);
		wr = w;
		rd = !w;
		smb = s;
		addr = a;
		be = b;
		wd = d;
		@(negedge clk);
		wr = 1'h0;
		rd = 1'h0;
		cmp("ack", 1'h1, ack);
		cmp("err", ee, err);
		if (!w) cmp("rdata", d, rdat);
	endtask

	// one descriptor; e is {forward, block, discard}
	task tlp(input logic c, input logic [4:0] d, input logic v,
		input logic [2:0] e);
		@(negedge clk);
		tv = 1'h1;
		ds = !v;
		us = v;
		idr = !v;
		cfg = c;
		hit = 1'h1;
		dev = d;
		vdm = v;
		@(negedge clk);
		tv = 1'h0;
		cmp("verdict", e, {fwd, blk, dis});
		cmp("credit", e[0], cred);
	endtask

	task boot(input logic s);
		strap = s;
		done = 1'h0;
		rst_n = 1'h0;
		repeat (6) @(negedge clk);
		cmp("quasi in reset", 1'h1, quasi);
		cmp("lock in reset", 1'h0, lock);
		rst_n = 1'h1;
		repeat (3) @(negedge clk);
	endtask

	// halt strap: load, then hold until an SMBus write clears the bit
	task t_halt;
		boot(1'h1);
		cmp("lock set", 1'h1, lock);
		acc(0, 0, 12'h000, 4'h0, 32'h0000_000C, 0);
		acc(1, 0, 12'h000, 4'hF, 32'hFFFF_FFFF, 0);
		acc(0, 0, 12'h000, 4'h0, 32'h0008_001C, 0);
		cmp("drop set", 1'h1, drop);
		done = 1'h1;
		repeat (2) @(negedge clk);
		tlp(0, 5'h03, 0, 3'h0);
		acc(1, 0, 12'h000, 4'h1, 32'h0000_0018, 0);
		cmp("quasi kept", 1'h1, quasi);
		acc(1, 1, 12'h000, 4'h1, 32'h0000_0018, 0);
		cmp("quasi left", 1'h0, quasi);
	endtask

	// run state: halt bit frozen, lock gates the budget unlock
	task t_run;
		acc(1, 0, 12'h000, 4'h1, 32'h0000_001C, 0);
		acc(0, 0, 12'h000, 4'h0, 32'h0008_0018, 0);
		acc(1, 0, 12'h000, 4'h1, 32'h0000_0010, 0);
		cmp("lock cleared", 1'h0, lock);
		acc(1, 0, 12'h000, 4'h1, 32'h0000_0000, 0);
		acc(0, 0, 12'h000, 4'h0, 32'h0008_0010, 0);
		cmp("budget writable", 1'h1, pbw);
		acc(1, 0, 12'h004, 4'hF, 32'hFFFF_FFFF, 1);
		acc(0, 0, 12'h004, 4'h0, 32'h0000_0000, 1);
		acc(0, 0, 12'h000, 4'h0, 32'h0008_0010, 0);
	endtask

	// every check level against config and plain, device 0 and 3
	task t_tlp;
		logic b;
		for (int l = 0; l < 3; l++) begin
			acc(1, 0, 12'h000, 4'h2, 32'(l) << 9, 0);
			cmp("level", l, lvl);
			for (int c = 0; c < 2; c++) begin
				for (int k = 0; k < 2; k++) begin
					b = (k == 1) && (l == 0 || (l == 1 && c == 1));
					tlp(c[0], 5'(3 * k), 0, {!b, b, 1'h0});
				end
			end
		end
		acc(1, 0, 12'h000, 4'h2, 32'h0000_0600, 0);
		cmp("level kept", 2'h2, lvl);
		acc(0, 0, 12'h000, 4'h0, 32'h0008_0410, 0);
		tlp(0, 5'h00, 1, 3'h1);
		acc(1, 0, 12'h000, 4'h4, 32'h0000_0000, 0);
		cmp("drop cleared", 1'h0, drop);
		tlp(0, 5'h00, 1, 3'h4);
	endtask

	// second reset, strap low: sticky fields cleared, straight to run
	task t_reboot;
		boot(1'h0);
		done = 1'h1;
		repeat (3) @(negedge clk);
		cmp("quasi after boot", 1'h0, quasi);
		acc(0, 0, 12'h000, 4'h0, 32'h0000_0008, 0);
	endtask

	task report_and_stop;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// main sequence
	initial begin
		t_halt;
		t_run;
		t_tlp;
		t_reboot;
		report_and_stop;
	end

	// watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		#100000;
		fail_count++;
		report_and_stop;
	end
endmodule
